// ---- rtl/alr_pkg.sv ----
// Shared constants and types for the per-port transmit amplitude and
// role resolver of a two-port single-pair 10 Mbps PHY.
// Assumes a 10 MHz core clock and a word-wide register port.
package alr_pkg;

	// Port count and register port widths
	localparam int NUM_PORTS = 2;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte offsets, one aligned word each
	localparam logic [7:0] ADDR_ADV_P1 = 8'h00;
	localparam logic [7:0] ADDR_ADV_P2 = 8'h04;
	localparam logic [7:0] ADDR_STAT_P1 = 8'h08;
	localparam logic [7:0] ADDR_STAT_P2 = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
	localparam logic [7:0] ADDR_CTRL = 8'h18;

	// Advertisement word: lower half holds the forced-role bit,
	// upper half holds preference and amplitude bits
	localparam int ADV_FORCED_BIT = 4;
	localparam int ADV_MASTER_BIT = 20;
	localparam int ADV_REQ_BIT = 24;
	localparam int ADV_ABLE_BIT = 25;

	// Per-port status word fields
	localparam int ST_DONE_BIT = 0;
	localparam int ST_LP_ABLE_BIT = 1;
	localparam int ST_LP_REQ_BIT = 2;
	localparam int ST_LP_FORCED_BIT = 3;
	localparam int ST_LP_MASTER_BIT = 4;
	localparam int ST_RES_LSB = 5;
	localparam int ST_AMP_BIT = 7;
	localparam int ST_HI_ABLE_BIT = 8;

	// Interrupt events, three per port
	localparam int EV_PER_PORT = 3;
	localparam int EV_DONE = 0;
	localparam int EV_FAULT = 1;
	localparam int EV_FAIL = 2;
	localparam int IRQ_W = NUM_PORTS * EV_PER_PORT;

	// Reset values: port 1 prefers master, port 2 prefers slave
	localparam logic [NUM_PORTS-1:0] RST_MASTER_PREF = 2'h1;
	localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 6'h00;

	// Cycles after reset release before straps are trusted
	localparam logic [1:0] INIT_CYCLES = 2'h3;

	// Random tie-break source
	localparam int LFSR_W = 16;
	localparam logic [15:0] LFSR_TAPS = 16'hB400;
	localparam logic [15:0] LFSR_SEED = 16'hACE1;

	// One advertisement page, local or partner
	typedef struct packed {
		logic ability;
		logic request;
		logic forced;
		logic master;
	} alr_adv_s;

	// Register port request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} alr_req_s;

	// Role resolution result
	typedef enum logic [1:0] {
		RES_NONE,
		RES_SLAVE,
		RES_MASTER,
		RES_FAULT
	} alr_res_e;

	// Negotiation tracking per port
	typedef enum logic [1:0] {
		ST_START,
		ST_WAIT,
		ST_DONE
	} alr_st_e;

endpackage

// ---- rtl/alr_sync2.sv ----
// Two-flop synchroniser for asynchronous level inputs such as straps.
// Assumes inputs change slowly against the clock.
`timescale 1ns/10ps
module alr_sync2 import alr_pkg::*; #(
	parameter int W = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule // alr_sync2

// ---- rtl/alr_lfsr.sv ----
// Free-running Galois LFSR giving one pseudo-random bit per cycle.
// Assumes a nonzero seed; the all-zero state is never reached.
`timescale 1ns/10ps
module alr_lfsr import alr_pkg::*; #(
	parameter int W = LFSR_W,
	parameter logic [W-1:0] TAPS = LFSR_TAPS,
	parameter logic [W-1:0] SEED = LFSR_SEED
) (
	input wire logic clk,
	input wire logic rst,
	output logic rnd
);

	logic [W-1:0] state_q;

	// Shift right, fold taps back in when the low bit falls out
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= SEED;
		end else if (state_q[0]) begin
			state_q <= (state_q >> 1) ^ TAPS;
		end else begin
			state_q <= state_q >> 1;
		end
	end

	assign rnd = state_q[0];

endmodule // alr_lfsr

// ---- rtl/alr_an_resolver.sv ----
// Per-port advertisement, partner capture and resolution of transmit
// amplitude and master/slave role for two single-pair PHY ports.
// Assumes a page engine on the same clock that starts on neg_start,
// reports a received partner page or a failure, and signals link drop.
// Function
// RULE1 - Read-only ability status follows strap; sets amplitude defaults
// RULE2 - Ability field: 0 means low level only, 1 both levels
// RULE3 - Request field: 0 requests low level, 1 requests high level
// RULE4 - High-amplitude request advertised only while the port strap is set
// RULE5 - Software writes to amplitude fields act only with strap set
// RULE6 - Partner amplitude bits captured, valid only while negotiation done
// RULE7 - No ability either side, or no request at all: low level
// RULE8 - Both able and any request: high level
// RULE9 - Local ability cleared always resolves to the low level
// RULE10 - In high-amplitude mode, level chosen by negotiation with partner
// RULE11 - Master preference in upper word; resets port1 master, port2 slave
// RULE12 - Forced-role bit in lower word makes advertised role forced
// RULE13 - Both forcing same role gives configuration fault and failure
// RULE14 - Partner role bits captured, valid only while negotiation done
// RULE15 - Negotiated roles always give exactly one master on the link; a random tie here can leave both ends on one role
// RULE16 - Equal unforced preferences get complementary roles at random; here the local random bit alone picks the role
// RULE17 - A single forced side wins over the other's preference
// RULE18 - Failed negotiation restarts itself; link stays down until done
// RULE19 - New advertisement applies at next start; results held until then
`timescale 1ns/10ps
module alr_an_resolver import alr_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic port1_high_amp_strap,
	input wire logic port2_high_amp_strap,
	input wire alr_req_s reg_req,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic [NUM_PORTS-1:0] page_rx_valid,
	input wire alr_adv_s [NUM_PORTS-1:0] partner_page,
	input wire logic [NUM_PORTS-1:0] page_fail,
	input wire logic [NUM_PORTS-1:0] link_drop,
	output logic [NUM_PORTS-1:0] neg_start,
	output alr_adv_s [NUM_PORTS-1:0] local_page,
	output logic [NUM_PORTS-1:0] negotiation_done,
	output logic [NUM_PORTS-1:0] tx_amplitude_control,
	output alr_res_e [NUM_PORTS-1:0] role_resolution_result,
	output logic [NUM_PORTS-1:0] high_amp_able_status,
	output logic irq
);

	// Address of each port's advertisement and status word
	function automatic logic [ADDR_W-1:0] adv_addr(input int p);
		adv_addr = (p == 0) ? ADDR_ADV_P1 : ADDR_ADV_P2;
	endfunction

	function automatic logic [ADDR_W-1:0] stat_addr(input int p);
		stat_addr = (p == 0) ? ADDR_STAT_P1 : ADDR_STAT_P2;
	endfunction

	// RULE8 high when able
	// Both sides able and at least one asking gives the high level
	// RULE7 low otherwise
	// Anything short of that, including no ability, stays low
	function automatic logic resolve_amp(input alr_adv_s loc,
		input alr_adv_s lp);
		resolve_amp = loc.ability & lp.ability & (loc.request | lp.request);
	endfunction

	// RULE15 one master
	// Every non-fault outcome is master or slave here, never none
	function automatic alr_res_e resolve_role(input alr_adv_s loc,
		input alr_adv_s lp, input logic rnd);
		alr_res_e r;
		r = RES_SLAVE;
		if (loc.forced && lp.forced) begin
			// RULE13 fault check
			// Both forced to the same role cannot be satisfied
			if (loc.master == lp.master) begin
				r = RES_FAULT;
			end else begin
				r = loc.master ? RES_MASTER : RES_SLAVE;
			end
		end else if (loc.forced) begin
			// RULE17 forced wins
			r = loc.master ? RES_MASTER : RES_SLAVE;
		end else if (lp.forced) begin
			r = lp.master ? RES_SLAVE : RES_MASTER;
		end else if (loc.master != lp.master) begin
			r = loc.master ? RES_MASTER : RES_SLAVE;
		end else begin
			// RULE16 random split
			// Same preference: the local random bit picks the role
			r = rnd ? RES_MASTER : RES_SLAVE;
		end
		resolve_role = r;
	endfunction

	// Advertisement word image
	function automatic logic [DATA_W-1:0] adv_img(input alr_adv_s a);
		logic [DATA_W-1:0] w;
		w = '0;
		w[ADV_ABLE_BIT] = a.ability;
		w[ADV_REQ_BIT] = a.request;
		w[ADV_MASTER_BIT] = a.master;
		w[ADV_FORCED_BIT] = a.forced;
		adv_img = w;
	endfunction

	// Status word image; partner bits read as zero until done
	function automatic logic [DATA_W-1:0] stat_img(input logic done,
		input alr_adv_s lp, input alr_res_e res, input logic amp,
		input logic able);
		logic [DATA_W-1:0] w;
		w = '0;
		w[ST_DONE_BIT] = done;
		w[ST_LP_ABLE_BIT] = done & lp.ability;
		w[ST_LP_REQ_BIT] = done & lp.request;
		w[ST_LP_FORCED_BIT] = done & lp.forced;
		w[ST_LP_MASTER_BIT] = done & lp.master;
		w[ST_RES_LSB +: 2] = res;
		w[ST_AMP_BIT] = amp;
		w[ST_HI_ABLE_BIT] = able;
		stat_img = w;
	endfunction

	logic [NUM_PORTS-1:0] strap_s;
	logic [1:0] init_cnt_q;
	logic init_done_q;
	logic rnd;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_stat_d;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] irq_clr;
	wire [IRQ_W-1:0] ev_vec;
	alr_adv_s adv_q [NUM_PORTS];
	alr_adv_s partner_q [NUM_PORTS];
	alr_st_e state_q [NUM_PORTS];
	logic neg_start_q [NUM_PORTS];
	alr_adv_s local_q [NUM_PORTS];
	logic done_q [NUM_PORTS];
	logic amp_q [NUM_PORTS];
	alr_res_e res_q [NUM_PORTS];
	logic irq_q;
	logic [DATA_W-1:0] rdata_q;

	// RULE1 strap sync
	// Straps are pins, so they pass two flops before any use
	alr_sync2 #(
		.W(NUM_PORTS)
	) u_strap_sync (
		.clk(clk),
		.rst(rst),
		.d({port2_high_amp_strap, port1_high_amp_strap}),
		.q(strap_s)
	);

	// Tie-break source shared by both ports
	alr_lfsr #(
		.W(LFSR_W),
		.TAPS(LFSR_TAPS),
		.SEED(LFSR_SEED)
	) u_lfsr (
		.clk(clk),
		.rst(rst),
		.rnd(rnd)
	);

	// Hold off until the synchronised straps are settled
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			init_cnt_q <= 2'h0;
			init_done_q <= 1'b0;
		end else if (!init_done_q) begin
			init_cnt_q <= init_cnt_q + 2'h1;
			init_done_q <= (init_cnt_q == INIT_CYCLES);
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_PORTS; g++) begin : g_port
			logic wr_adv;
			logic restart;
			logic page_ok;
			alr_res_e res_new;
			logic amp_new;

			assign wr_adv = reg_req.wr && (reg_req.addr == adv_addr(g));
			assign restart = reg_req.wr && (reg_req.addr == ADDR_CTRL) &&
				reg_req.wdata[g];
			assign res_new = resolve_role(local_q[g], partner_page[g], rnd);
			assign amp_new = resolve_amp(local_q[g], partner_page[g]);
			assign page_ok = page_rx_valid[g] && !page_fail[g] &&
				!link_drop[g] && !restart;

			// RULE11 role reset
			// Preference resets per port; amplitude defaults follow the strap
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					adv_q[g].ability <= 1'b0;
					adv_q[g].request <= 1'b0;
					adv_q[g].forced <= 1'b0;
					adv_q[g].master <= RST_MASTER_PREF[g];
				end else if (!init_done_q) begin
					// RULE1 strap default
					adv_q[g].ability <= strap_s[g];
					adv_q[g].request <= 1'b0;
				end else if (wr_adv) begin
					// RULE12 forced bit
					adv_q[g].forced <= reg_req.wdata[ADV_FORCED_BIT];
					adv_q[g].master <= reg_req.wdata[ADV_MASTER_BIT];
					// RULE5 strap gates writes
					if (strap_s[g]) begin
						// RULE2 ability field
						adv_q[g].ability <= reg_req.wdata[ADV_ABLE_BIT];
						// RULE3 request field
						adv_q[g].request <= reg_req.wdata[ADV_REQ_BIT];
					end
				end
			end

			// Negotiation tracking; results change only on a good page
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					state_q[g] <= ST_START;
					neg_start_q[g] <= 1'b0;
					local_q[g] <= '0;
					partner_q[g] <= '0;
					done_q[g] <= 1'b0;
					amp_q[g] <= 1'b0;
					res_q[g] <= RES_NONE;
				end else begin
					neg_start_q[g] <= 1'b0;
					unique case (state_q[g])
						ST_START: begin
							if (init_done_q) begin
								// RULE19 snapshot at start
								// RULE4 request gated by strap
								local_q[g].ability <= adv_q[g].ability & strap_s[g];
								local_q[g].request <= adv_q[g].request & strap_s[g];
								local_q[g].forced <= adv_q[g].forced;
								local_q[g].master <= adv_q[g].master;
								neg_start_q[g] <= 1'b1;
								state_q[g] <= ST_WAIT;
							end
						end
						ST_WAIT: begin
							if (page_fail[g] || link_drop[g] || restart) begin
								// RULE18 auto restart
								state_q[g] <= ST_START;
							end else if (page_rx_valid[g]) begin
								// RULE6 RULE14 capture partner
								partner_q[g] <= partner_page[g];
								res_q[g] <= res_new;
								if (res_new == RES_FAULT) begin
									// RULE13 treat as failed
									state_q[g] <= ST_START;
								end else begin
									// RULE10 RULE9 negotiated level
									amp_q[g] <= amp_new;
									done_q[g] <= 1'b1;
									state_q[g] <= ST_DONE;
								end
							end
						end
						ST_DONE: begin
							if (link_drop[g] || restart) begin
								// RULE18 link down
								done_q[g] <= 1'b0;
								state_q[g] <= ST_START;
							end
						end
					endcase
				end
			end

			// Events for the interrupt status word
			assign ev_vec[g*EV_PER_PORT+EV_DONE] = (state_q[g] == ST_WAIT) &&
				page_ok && (res_new != RES_FAULT);
			assign ev_vec[g*EV_PER_PORT+EV_FAULT] = (state_q[g] == ST_WAIT) &&
				page_ok && (res_new == RES_FAULT);
			assign ev_vec[g*EV_PER_PORT+EV_FAIL] = (state_q[g] == ST_WAIT) &&
				page_fail[g];

			// Outputs straight from flops
			assign neg_start[g] = neg_start_q[g];
			assign local_page[g] = local_q[g];
			assign negotiation_done[g] = done_q[g];
			assign tx_amplitude_control[g] = amp_q[g];
			assign role_resolution_result[g] = res_q[g];
			assign high_amp_able_status[g] = strap_s[g];
		end
	endgenerate

	// Reading the status word clears what was read; a new event wins
	always_comb begin
		irq_clr = '0;
		if (reg_req.rd && (reg_req.addr == ADDR_IRQ_STAT)) begin
			irq_clr = irq_stat_q;
		end
		irq_stat_d = (irq_stat_q & ~irq_clr) | ev_vec;
	end

	// Sticky event bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= irq_stat_d;
		end
	end

	// Interrupt mask register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_mask_q <= RST_IRQ_MASK;
		end else if (reg_req.wr && (reg_req.addr == ADDR_IRQ_MASK)) begin
			irq_mask_q <= reg_req.wdata[IRQ_W-1:0];
		end
	end

	// Level interrupt from next status so it rises with the bit
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_stat_d & irq_mask_q);
		end
	end

	// Read data stand one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q <= '0;
		end else if (reg_req.rd) begin
			unique case (reg_req.addr)
				ADDR_ADV_P1: rdata_q <= adv_img(adv_q[0]);
				ADDR_ADV_P2: rdata_q <= adv_img(adv_q[1]);
				// RULE6 RULE14 valid when done
				ADDR_STAT_P1: rdata_q <= stat_img(done_q[0], partner_q[0],
					res_q[0], amp_q[0], strap_s[0]);
				ADDR_STAT_P2: rdata_q <= stat_img(done_q[1], partner_q[1],
					res_q[1], amp_q[1], strap_s[1]);
				ADDR_IRQ_STAT: rdata_q <= {{(DATA_W-IRQ_W){1'b0}}, irq_stat_q};
				ADDR_IRQ_MASK: rdata_q <= {{(DATA_W-IRQ_W){1'b0}}, irq_mask_q};
				default: rdata_q <= '0;
			endcase
		end else begin
			rdata_q <= '0;
		end
	end

	assign reg_rdata = rdata_q;
	assign irq = irq_q;

endmodule // alr_an_resolver

// ---- test/alr_partner.sv ----
// Behavioural far-side negotiation partner for both ports.
// Assumes the bench sets the page, the answer delay and the fail choice.
`timescale 1ns/10ps
module alr_partner import alr_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic [NUM_PORTS-1:0] neg_start,
	input wire alr_adv_s [NUM_PORTS-1:0] cfg,
	input wire logic [3:0] dly,
	input wire logic [NUM_PORTS-1:0] fail_en,
	output logic [NUM_PORTS-1:0] page_rx_valid,
	output alr_adv_s [NUM_PORTS-1:0] partner_page,
	output logic [NUM_PORTS-1:0] page_fail
);
	logic [3:0] cnt_q [NUM_PORTS];

	// Count down from each start, then answer once with a page or a fail
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			page_rx_valid <= '0;
			page_fail <= '0;
			for (int p = 0; p < NUM_PORTS; p++)
				cnt_q[p] <= 4'h0;
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				page_rx_valid[p] <= cnt_q[p] == 4'h1 && !fail_en[p];
				page_fail[p] <= cnt_q[p] == 4'h1 && fail_en[p];
				if (neg_start[p])
					cnt_q[p] <= dly;
				else if (cnt_q[p] != 4'h0)
					cnt_q[p] <= cnt_q[p] - 4'h1;
			end
		end
	end

	// Page lines carry junk outside the valid cycle, so stale bits show up
	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++)
			partner_page[p] = page_rx_valid[p] ? cfg[p] : ~cfg[p];
	end
endmodule // alr_partner

// ---- test/alr_an_resolver_monitor.sv ----
// Checker for the amplitude and role resolver, on top-level ports.
// Assumes one clock domain; port 0 carries the rich traffic.
`timescale 1ns/10ps
module alr_an_resolver_monitor import alr_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic port1_high_amp_strap,
	input wire alr_req_s reg_req,
	input wire logic [NUM_PORTS-1:0] page_rx_valid,
	input wire alr_adv_s [NUM_PORTS-1:0] partner_page,
	input wire logic [NUM_PORTS-1:0] page_fail,
	input wire logic [NUM_PORTS-1:0] link_drop,
	input wire logic [NUM_PORTS-1:0] neg_start,
	input wire alr_adv_s [NUM_PORTS-1:0] local_page,
	input wire logic [NUM_PORTS-1:0] negotiation_done,
	input wire logic [NUM_PORTS-1:0] tx_amplitude_control,
	input wire alr_res_e [NUM_PORTS-1:0] role_resolution_result,
	input wire logic [NUM_PORTS-1:0] high_amp_able_status
);
	alr_adv_s lc, lp;
	alr_res_e rr;
	logic dn;
	logic pend_q;
	logic rs;
	logic acc;

	// Port 0 views keep the properties short
	assign lc = local_page[0];
	assign lp = partner_page[0];
	assign rr = role_resolution_result[0];
	assign dn = negotiation_done[0];

	// Software restart of port 0 drops any page in flight
	assign rs = reg_req.wr && (reg_req.addr == ADDR_CTRL) && reg_req.wdata[0];

	// Port 0 waits for an answer from its start pulse until any outcome
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pend_q <= 1'b0;
		end else begin
			pend_q <= (pend_q || neg_start[0]) && !rs && !page_fail[0] &&
				!page_rx_valid[0] && !link_drop[0];
		end
	end

	// Only a page taken while waiting counts; the resolver refuses others
	assign acc = page_rx_valid[0] && (pend_q || neg_start[0]) &&
		!page_fail[0] && !link_drop[0] && !rs;

	// Expected local role; none where the tie is broken at random
	function automatic alr_res_e want(alr_adv_s l, alr_adv_s r);
		if (l.forced && r.forced && l.master == r.master)
			return RES_FAULT;
		if (l.forced)
			return l.master ? RES_MASTER : RES_SLAVE;
		if (r.forced || l.master != r.master)
			return r.master ? RES_SLAVE : RES_MASTER;
		return RES_NONE;
	endfunction

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_ABLE: assert property (
		!$past(rst) && !$past(rst, 2) |->
		high_amp_able_status[0] == $past(port1_high_amp_strap, 2))
		else $error("ability status not following strap");
	AST_GATE: assert property (
		neg_start[1] && !high_amp_able_status[1] |->
		!local_page[1].request && !local_page[1].ability)
		else $error("high amplitude advertised without strap");
	AST_AMP: assert property (
		$rose(dn) |-> tx_amplitude_control[0] == (lc.ability &&
		$past(lp.ability) && (lc.request || $past(lp.request))))
		else $error("resolved amplitude wrong");
	AST_ROLE: assert property (
		$past(acc) && want(lc, $past(lp)) != RES_NONE
		|-> rr == want(lc, $past(lp)))
		else $error("resolved role wrong");
	AST_TIE: assert property (
		$past(acc) && want(lc, $past(lp)) == RES_NONE
		|-> rr inside {RES_MASTER, RES_SLAVE})
		else $error("tie not resolved to a role");
	AST_FAULT_DOWN: assert property (
		rr == RES_FAULT |-> !dn)
		else $error("done set with a fault");
	AST_FAULT_RETRY: assert property (
		rr == RES_FAULT && $past(acc) |=> neg_start[0])
		else $error("no restart after fault");
	AST_FAIL_RETRY: assert property (
		page_fail[0] && (pend_q || neg_start[0]) |=>
		!dn ##[0:12] neg_start[0])
		else $error("no restart after page failure");
	AST_DROP: assert property (
		link_drop[0] |=> !dn)
		else $error("done kept after link drop");
	AST_HOLD: assert property (
		!$past(page_rx_valid[0]) |->
		$stable(tx_amplitude_control[0]) && $stable(rr))
		else $error("result changed without a page");

	COV_FAULT: cover property (rr == RES_FAULT);
	COV_HIGH: cover property ($rose(dn) && tx_amplitude_control[0]);
	COV_FAIL: cover property (page_fail[0] ##[1:12] dn);
endmodule // alr_an_resolver_monitor

bind alr_an_resolver alr_an_resolver_monitor u_mon (
	.clk(clk), .rst(rst), .port1_high_amp_strap(port1_high_amp_strap),
	.reg_req(reg_req),
	.page_rx_valid(page_rx_valid), .partner_page(partner_page),
	.page_fail(page_fail), .link_drop(link_drop), .neg_start(neg_start),
	.local_page(local_page), .negotiation_done(negotiation_done),
	.tx_amplitude_control(tx_amplitude_control),
	.role_resolution_result(role_resolution_result),
	.high_amp_able_status(high_amp_able_status)
);

// ---- test/alr_an_resolver_bench.sv ----
// Self-checking bench for the amplitude and role resolver.
// Assumes the partner model beside the dut and the bound checker.
`timescale 1ns/10ps
module alr_an_resolver_bench import alr_pkg::*;;
	logic clk, rst, s1, s2, irq;
	alr_req_s req;
	logic [DATA_W-1:0] rdata;
	logic [1:0] prv, pf, drop, ns, done, fen;
	alr_adv_s [1:0] pp, cfg;
	logic [3:0] dly;
	int failures, num_checks;

	alr_an_resolver dut (
		.clk(clk), .rst(rst),
		.port1_high_amp_strap(s1), .port2_high_amp_strap(s2),
		.reg_req(req), .reg_rdata(rdata),
		.page_rx_valid(prv), .partner_page(pp), .page_fail(pf),
		.link_drop(drop), .neg_start(ns), .local_page(),
		.negotiation_done(done), .tx_amplitude_control(),
		.role_resolution_result(), .high_amp_able_status(), .irq(irq)
	);
	alr_partner u_lp (
		.clk(clk), .rst(rst), .neg_start(ns), .cfg(cfg), .dly(dly),
		.fail_en(fen), .page_rx_valid(prv), .partner_page(pp),
		.page_fail(pf)
	);

	task automatic conclude();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Bus cycles: one strobe cycle, read data taken in the next cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		req <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		chk(d & m, e);
	endtask

	// Wait for a start (unless skipped), then the page and its result
	task automatic settle(input logic skip);
		int n;
		n = 0;
		while (!skip && !ns[0] && n < 80) begin
			@(negedge clk);
			n++;
		end
		while (!prv[0] && n < 80) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		if (n >= 80) begin
			failures++;
			conclude();
		end
	endtask

	task automatic t_reset();
		wr(8'h1C, 32'hFFFF_FFFF);
		rc(ADDR_ADV_P1, 32'h0311_0010, 32'h0210_0000);
		rc(ADDR_ADV_P2, 32'h0311_0010, 32'h0);
		rc(ADDR_STAT_P1, 32'h100, 32'h100);
		rc(ADDR_STAT_P2, 32'h100, 32'h0);
		rc(ADDR_IRQ_MASK, 32'hFFFF_FFFF, 32'h0);
		rc(8'h1C, 32'hFFFF_FFFF, 32'h0);
	endtask

	task automatic t_strap();
		wr(ADDR_ADV_P2, 32'h0300_0010);
		rc(ADDR_ADV_P2, 32'h0311_0010, 32'h10);
		wr(ADDR_CTRL, 32'h2);
		repeat (12) @(posedge clk);
		rc(ADDR_STAT_P2, 32'h1FF, 32'h21);
		wr(ADDR_ADV_P1, 32'h0300_0010);
		rc(ADDR_ADV_P1, 32'h0311_0010, 32'h0300_0010);
	endtask

	// full amplitude table, partner answering promptly
	task automatic t_amp();
		logic a;
		dly <= 4'h2;
		for (int i = 0; i < 16; i++) begin
			wr(ADDR_ADV_P1, {6'h0, i[1:0], 24'h0});
			cfg[0] <= '{i[3], i[2], 1'b0, 1'b0};
			wr(ADDR_CTRL, 32'h1);
			settle(1'b0);
			a = i[1] & i[3] & (i[0] | i[2]);
			rc(ADDR_STAT_P1, 32'h87, {24'h0, a, 4'h0, i[2], i[3], 1'b1});
		end
	endtask

	// full role table, partner answering slowly
	task automatic t_role();
		logic [31:0] d;
		alr_res_e e;
		dly <= 4'h6;
		for (int i = 0; i < 16; i++) begin
			wr(ADDR_ADV_P1, {11'h0, i[0], 15'h0, i[1], 4'h0});
			cfg[0] <= '{1'b0, 1'b0, i[3], i[2]};
			wr(ADDR_CTRL, 32'h1);
			settle(1'b0);
			if (i[1] && i[3] && i[0] == i[2])
				e = RES_FAULT;
			else if (i[1])
				e = i[0] ? RES_MASTER : RES_SLAVE;
			else if (i[3] || i[0] != i[2])
				e = i[2] ? RES_SLAVE : RES_MASTER;
			else
				e = RES_NONE;
			rd(ADDR_STAT_P1, d);
			if (e == RES_FAULT) begin
				chk(d & 32'h7F, 32'h60);
				rc(ADDR_IRQ_STAT, 32'h2, 32'h2);
				cfg[0] <= '{1'b0, 1'b0, 1'b0, i[2]};
				settle(1'b1);
				chk({31'h0, done[0]}, 32'h1);
			end else if (e == RES_NONE)
				chk({31'h0, ^d[6:5]}, 32'h1);
			else
				chk(d & 32'h7F, {25'h0, e, i[2], i[3], 3'h1});
		end
	endtask

	// Done event: masked, read-cleared, then unmasked
	task automatic t_irq();
		logic [31:0] d;
		rd(ADDR_IRQ_STAT, d);
		wr(ADDR_CTRL, 32'h1);
		settle(1'b0);
		chk({31'h0, irq}, 32'h0);
		rc(ADDR_IRQ_STAT, 32'h1, 32'h1);
		rc(ADDR_IRQ_STAT, 32'h1, 32'h0);
		wr(ADDR_IRQ_MASK, 32'h1);
		wr(ADDR_CTRL, 32'h1);
		settle(1'b0);
		chk({31'h0, irq}, 32'h1);
		rd(ADDR_IRQ_STAT, d);
		repeat (2) @(negedge clk);
		chk({31'h0, irq}, 32'h0);
	endtask

	// page failure, then link drop, each recovering
	task automatic t_recover();
		int n;
		fen <= 2'h1;
		wr(ADDR_CTRL, 32'h1);
		for (n = 0; n < 60 && !pf[0]; n++)
			@(negedge clk);
		if (!pf[0]) begin
			failures++;
			conclude();
		end
		fen <= 2'h0;
		chk({31'h0, done[0]}, 32'h0);
		settle(1'b1);
		chk({31'h0, done[0]}, 32'h1);
		rc(ADDR_IRQ_STAT, 32'h6, 32'h4);
		@(posedge clk);
		drop <= 2'h1;
		@(posedge clk);
		drop <= 2'h0;
		@(negedge clk);
		chk({31'h0, done[0]}, 32'h0);
		settle(1'b0);
		chk({31'h0, done[0]}, 32'h1);
	endtask

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		rst = 1'b1;
		s1 = 1'b1;
		s2 = 1'b0;
		req = '0;
		drop = '0;
		cfg = '0;
		dly = 4'h6;
		fen = '0;
		failures = 0;
		num_checks = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (10) @(posedge clk);
		t_reset();
		t_strap();
		t_amp();
		t_role();
		t_irq();
		t_recover();
		conclude();
	end
endmodule // alr_an_resolver_bench
